// ==== design/eep_pkg.sv ====
// Shared constants, carrier types and ECC helpers for the serial EEPROM slave.
package eep_pkg;

  localparam int CLK_HZ = 125_000_000;
  localparam int SCL_MAX_HZ = 1_000_000;
  // Internal programming time; the figure is a plain default, shorten freely in simulation.
  localparam int PROG_TIME_US = 20;
  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] PROG_LAST = 12'(PROG_CYCLES - 1);

  localparam int ARRAY_BYTES = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGES = 128;
  localparam int ADDR_W = 12;
  localparam int OFFS_W = 5;
  localparam int MEM_AW = 13;
  localparam int BYTE_W = 8;
  localparam int ECC_W = 12;

  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int HI_LOCK_BIT = 2;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [5:0] COPY_END = 6'h21;

  typedef enum logic [1:0] {EV_ADDR, EV_WRITE, EV_READ, EV_LOCK} eep_evkind_e;

  typedef struct packed {
    eep_evkind_e kind;
    logic idSel;
    logic [11:0] addr;
    logic [7:0] data;
  } eep_evt_s;

  typedef enum logic [2:0] {LS_IDLE, LS_SELECT, LS_ADDR_HI, LS_ADDR_LO, LS_WRITE, LS_READ}
    eep_link_e;

  typedef struct packed {
    eep_link_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackNow;
    logic rw;
    logic idSel;
    logic [7:0] addrHi;
    logic [7:0] tx;
    logic startSeen;
    eep_evt_s evt;
    logic evtTog;
    logic [2:0] strapM;
    logic [2:0] strapS;
    logic wpM;
    logic wpS;
    logic busyM;
    logic busyS;
    logic lockM;
    logic lockS;
  } eep_lpos_s;

  typedef struct packed {
    logic oe;
    logic out;
  } eep_lneg_s;

  typedef struct packed {
    logic sclM;
    logic sclS;
    logic sdaM;
    logic sdaS;
    logic sdaP;
    logic startTog;
    logic togM;
    logic togS;
    logic togSeen;
    eep_evt_s [1:0] fifo;
    logic wrP;
    logic rdP;
    logic [1:0] cnt;
    logic [11:0] ptr;
    logic ptrId;
    logic [6:0] wPage;
    logic wId;
    logic [31:0] mask;
    logic lockPend;
    logic locked;
    logic stopPend;
    logic busy;
    logic [11:0] progCnt;
    logic [5:0] copyIdx;
    logic [7:0] rdByte;
  } eep_core_s;

  function automatic logic [3:0] eccSyndrome(input logic [11:0] c);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < ECC_W; i++)
    begin
      if (c[i])
      begin
        s = s ^ 4'(i + 1);
      end
    end
    return s;
  endfunction : eccSyndrome

  // Hamming code over twelve bits: parity at positions 1, 2, 4 and 8.
  function automatic logic [11:0] eccEncode(input logic [7:0] d);
    logic [11:0] c;
    logic [3:0] s;
    c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
    s = eccSyndrome(c);
    c[0] = s[0];
    c[1] = s[1];
    c[3] = s[2];
    c[7] = s[3];
    return c;
  endfunction : eccEncode

  // A single flipped bit anywhere in the word is corrected silently.
  function automatic logic [7:0] eccDecode(input logic [11:0] c);
    logic [11:0] f;
    logic [3:0] s;
    f = c;
    s = eccSyndrome(c);
    if (s != 4'h0 && s <= 4'hC)
    begin
      f[s - 4'h1] = ~c[s - 4'h1];
    end
    return {f[11:8], f[6:4], f[2]};
  endfunction : eccDecode

  function automatic logic [12:0] memAddr(input logic id, input logic [11:0] a);
    return id ? {1'b1, 7'h00, a[4:0]} : {1'b0, a};
  endfunction : memAddr

endpackage : eep_pkg

// ==== design/eep_mem.sv ====
// Simple dual-port memory with one write port and a registered read port.
`timescale 1ns/1ps
module eep_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset, clears only the read register.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] waddr, // Write address.
  input wire logic [DW-1:0] wdata, // Write data.
  input wire logic [AW-1:0] raddr, // Read address.
  output logic [DW-1:0] rdata // Read data, one cycle after the address.
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : eep_mem

// ==== design/eep_i2c_slave.sv ====
// Two-wire serial EEPROM slave with chip straps, write protect and a lockable ID page.
`timescale 1ns/1ps
module eep_i2c_slave (
  input wire logic clk, // Core clock, 125 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic scl, // Serial clock from the bus master.
  input wire logic sdaIn, // Resolved level of the serial data line.
  output logic sdaOut, // Level driven when enabled, always low.
  output logic sdaOe, // High while the block pulls the data line low.
  input wire logic [2:0] chipAddrStraps, // Chip address straps.
  input wire logic writeProtect, // Write protect input, high blocks writes.
  output logic progBusy, // High during the internal programming cycle.
  output logic idLocked // High once the ID page is locked.
);

  eep_pkg::eep_lpos_s lp_q;
  eep_pkg::eep_lpos_s lp_d;
  eep_pkg::eep_lneg_s ln_q;
  eep_pkg::eep_lneg_s ln_d;
  eep_pkg::eep_core_s cq;
  eep_pkg::eep_core_s cd;

  logic arrWe;
  logic [12:0] arrWaddr;
  logic [11:0] arrWdata;
  logic [12:0] arrRaddr;
  logic [11:0] arrRdata;
  logic stWe;
  logic [4:0] stWaddr;
  logic [7:0] stWdata;
  logic [7:0] stRdata;

  // Link side, rising edge: shift in bits and walk the byte sequence.
  always_comb
  begin
    eep_pkg::eep_link_e st;
    logic [3:0] cnt;
    logic [7:0] nb;
    lp_d = lp_q;
    st = lp_q.st;
    cnt = lp_q.bitCnt;
    nb = {lp_q.shift[6:0], sdaIn};
    lp_d.strapM = chipAddrStraps;
    lp_d.strapS = lp_q.strapM;
    lp_d.wpM = writeProtect;
    lp_d.wpS = lp_q.wpM;
    lp_d.busyM = cq.busy;
    lp_d.busyS = lp_q.busyM;
    lp_d.lockM = cq.locked;
    lp_d.lockS = lp_q.lockM;
    // The Start toggle comes from the core side; it settles long before the
    // first rising clock edge of the select byte, so a direct read is safe.
    if (cq.startTog != lp_q.startSeen)
    begin
      lp_d.startSeen = cq.startTog;
      st = eep_pkg::LS_SELECT;
      cnt = 4'h0;
    end
    lp_d.st = st;
    lp_d.bitCnt = cnt;
    lp_d.ackNow = 1'b0;
    if (st == eep_pkg::LS_IDLE)
    begin
      lp_d.bitCnt = 4'h0;
    end
    else if (cnt != eep_pkg::BIT_LAST)
    begin
      lp_d.shift = nb;
      lp_d.bitCnt = cnt + 4'h1;
      if (cnt == eep_pkg::BIT_LAST - 4'h1)
      begin
        case (st)
          eep_pkg::LS_SELECT:
          begin
            lp_d.idSel = (nb[7:4] == eep_pkg::TYPE_ID);
            lp_d.rw = nb[0];
            // Selection is refused while programming, so new requests are ignored.
            lp_d.ackNow = (nb[7:4] == eep_pkg::TYPE_ARRAY || nb[7:4] == eep_pkg::TYPE_ID)
              && (nb[3:1] == lp_q.strapS)
              && !lp_q.busyS;
          end
          eep_pkg::LS_ADDR_HI, eep_pkg::LS_ADDR_LO:
          begin
            lp_d.ackNow = 1'b1;
          end
          eep_pkg::LS_WRITE:
          begin
            lp_d.ackNow = !lp_q.wpS && !(lp_q.idSel && lp_q.lockS);
          end
          default:
          begin
            lp_d.ackNow = 1'b0;
          end
        endcase
      end
    end
    else
    begin
      lp_d.bitCnt = 4'h0;
      case (st)
        eep_pkg::LS_SELECT:
        begin
          if (!lp_q.ackNow)
          begin
            lp_d.st = eep_pkg::LS_IDLE;
          end
          else if (lp_q.rw)
          begin
            lp_d.st = eep_pkg::LS_READ;
            lp_d.tx = cq.rdByte;
            lp_d.evt = '{eep_pkg::EV_READ, lp_q.idSel, 12'h000, 8'h00};
            lp_d.evtTog = ~lp_q.evtTog;
          end
          else
          begin
            lp_d.st = eep_pkg::LS_ADDR_HI;
          end
        end
        eep_pkg::LS_ADDR_HI:
        begin
          lp_d.addrHi = lp_q.shift;
          lp_d.st = eep_pkg::LS_ADDR_LO;
        end
        eep_pkg::LS_ADDR_LO:
        begin
          lp_d.st = eep_pkg::LS_WRITE;
          lp_d.evt = '{eep_pkg::EV_ADDR, lp_q.idSel, {lp_q.addrHi[3:0], lp_q.shift}, 8'h00};
          lp_d.evtTog = ~lp_q.evtTog;
        end
        eep_pkg::LS_WRITE:
        begin
          // A refused byte raises no event, so nothing is staged for programming.
          if (lp_q.ackNow)
          begin
            lp_d.evt = '{(lp_q.idSel && lp_q.addrHi[eep_pkg::HI_LOCK_BIT]) ?
                         eep_pkg::EV_LOCK : eep_pkg::EV_WRITE,
                         lp_q.idSel, 12'h000, lp_q.shift};
            lp_d.evtTog = ~lp_q.evtTog;
          end
        end
        eep_pkg::LS_READ:
        begin
          if (sdaIn)
          begin
            lp_d.st = eep_pkg::LS_IDLE;
          end
          else
          begin
            lp_d.tx = cq.rdByte;
            lp_d.evt = '{eep_pkg::EV_READ, lp_q.idSel, 12'h000, 8'h00};
            lp_d.evtTog = ~lp_q.evtTog;
          end
        end
        default:
        begin
          lp_d.st = eep_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // Link side, falling edge: drive the data line.
  always_comb
  begin
    ln_d = ln_q;
    ln_d.out = 1'b0;
    if (lp_q.st == eep_pkg::LS_READ && lp_q.bitCnt != eep_pkg::BIT_LAST)
    begin
      ln_d.oe = ~lp_q.tx[~lp_q.bitCnt[2:0]];
    end
    else
    begin
      ln_d.oe = lp_q.ackNow;
    end
  end

  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      lp_q <= '0;
    end
    else
    begin
      lp_q <= lp_d;
    end
  end

  always_ff @(negedge scl or posedge rst)
  begin
    if (rst)
    begin
      ln_q <= '0;
    end
    else
    begin
      ln_q <= ln_d;
    end
  end

  // Core side: Stop detection, event buffer, pointer, staging and programming.
  always_comb
  begin
    eep_pkg::eep_evt_s ev;
    logic push;
    logic pop;
    logic [4:0] cOff;
    cd = cq;
    ev = cq.fifo[cq.rdP];
    push = 1'b0;
    pop = 1'b0;
    cOff = 5'(cq.copyIdx - 6'h01);
    arrWe = 1'b0;
    arrWaddr = 13'h0000;
    arrWdata = 12'h000;
    stWe = 1'b0;
    stWaddr = cq.ptr[4:0];
    stWdata = ev.data;
    cd.sclM = scl;
    cd.sclS = cq.sclM;
    cd.sdaM = sdaIn;
    cd.sdaS = cq.sdaM;
    cd.sdaP = cq.sdaS;
    cd.togM = lp_q.evtTog;
    cd.togS = cq.togM;
    // At 1 MHz SCL a high phase spans dozens of core cycles, so the
    // synchronised copies always see a Stop while SCL is still high.
    if (cq.sclS && cq.sdaS && !cq.sdaP)
    begin
      cd.stopPend = 1'b1;
    end
    // Start is seen here because the bus may idle with SCL high after a Stop,
    // where no link clock edge would ever reveal the falling data line.
    if (cq.sclS && !cq.sdaS && cq.sdaP)
    begin
      cd.startTog = ~cq.startTog;
    end
    // The buffer only takes an event when a slot is free; otherwise the
    // toggle stays unanswered and the event waits on the link side.
    if (cq.togS != cq.togSeen && cq.cnt != eep_pkg::FIFO_FULL)
    begin
      push = 1'b1;
      cd.fifo[cq.wrP] = lp_q.evt;
      cd.wrP = ~cq.wrP;
      cd.togSeen = cq.togS;
    end
    // Events are held back while programming, so the buffer really fills.
    if (cq.cnt != 2'h0 && !cq.busy)
    begin
      pop = 1'b1;
      cd.rdP = ~cq.rdP;
      case (ev.kind)
        eep_pkg::EV_ADDR:
        begin
          cd.ptr = ev.addr;
          cd.ptrId = ev.idSel;
          cd.wPage = ev.addr[11:5];
          cd.wId = ev.idSel;
          cd.mask = 32'h00000000;
          cd.lockPend = 1'b0;
        end
        eep_pkg::EV_WRITE:
        begin
          if (!(cq.ptrId && cq.locked))
          begin
            stWe = 1'b1;
            cd.mask[cq.ptr[4:0]] = 1'b1;
            cd.ptr[4:0] = cq.ptr[4:0] + 5'h01;
          end
        end
        eep_pkg::EV_LOCK:
        begin
          cd.lockPend = !cq.locked;
        end
        default:
        begin
          cd.ptr[4:0] = cq.ptr[4:0] + 5'h01;
          if (!cq.ptrId)
          begin
            cd.ptr = cq.ptr + 12'h001;
          end
        end
      endcase
    end
    cd.cnt = cq.cnt + {1'b0, push} - {1'b0, pop};
    if (cq.stopPend && cq.cnt == 2'h0 && cq.togS == cq.togSeen && !cq.busy)
    begin
      cd.stopPend = 1'b0;
      if (cq.mask != 32'h00000000 || cq.lockPend)
      begin
        cd.busy = 1'b1;
        cd.progCnt = 12'h000;
        cd.copyIdx = 6'h00;
      end
    end
    if (cq.busy)
    begin
      cd.progCnt = cq.progCnt + 12'h001;
      if (cq.copyIdx != eep_pkg::COPY_END)
      begin
        cd.copyIdx = cq.copyIdx + 6'h01;
      end
      if (cq.copyIdx != 6'h00 && cq.copyIdx != eep_pkg::COPY_END && cq.mask[cOff])
      begin
        arrWe = 1'b1;
        arrWaddr = eep_pkg::memAddr(cq.wId, {cq.wPage, cOff});
        arrWdata = eep_pkg::eccEncode(stRdata);
      end
      if (cq.progCnt == eep_pkg::PROG_LAST)
      begin
        cd.busy = 1'b0;
        cd.mask = 32'h00000000;
        if (cq.lockPend)
        begin
          cd.locked = 1'b1;
          cd.lockPend = 1'b0;
        end
      end
    end
    arrRaddr = eep_pkg::memAddr(cq.ptrId, cq.ptr);
    cd.rdByte = eep_pkg::eccDecode(arrRdata);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cq <= '0;
    end
    else
    begin
      cq <= cd;
    end
  end

  // Array and ID page share one ECC-protected store; the ID page sits above 4 KB.
  eep_mem #(.AW(eep_pkg::MEM_AW), .DW(eep_pkg::ECC_W)) u_array (
    .clk(clk),
    .rst(rst),
    .we(arrWe),
    .waddr(arrWaddr),
    .wdata(arrWdata),
    .raddr(arrRaddr),
    .rdata(arrRdata)
  );

  eep_mem #(.AW(eep_pkg::OFFS_W), .DW(eep_pkg::BYTE_W)) u_stage (
    .clk(clk),
    .rst(rst),
    .we(stWe),
    .waddr(stWaddr),
    .wdata(stWdata),
    .raddr(cq.copyIdx[4:0]),
    .rdata(stRdata)
  );

  assign sdaOut = ln_q.out;
  assign sdaOe = ln_q.oe;
  assign progBusy = cq.busy;
  assign idLocked = cq.locked;

endmodule : eep_i2c_slave

// ==== sim/eep_slave_properties.sv ====
// Port-level assertions for the serial EEPROM slave.
`timescale 1ns/1ps
module eep_slave_properties (
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic scl, // Serial clock.
  input wire logic sdaIn, // Resolved data line.
  input wire logic sdaOut, // Driven data level.
  input wire logic sdaOe, // Pull-down enable.
  input wire logic [2:0] chipAddrStraps, // Chip address straps.
  input wire logic writeProtect, // Write protect input.
  input wire logic progBusy, // Programming flag.
  input wire logic idLocked // Lock flag.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [12:0] busyCnt_q;
  logic [3:0] stopAge_q;

  // The stop age saturates so that a lone busy pulse long after any Stop still fails.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busyCnt_q <= 13'h0000;
      stopAge_q <= 4'hF;
    end
    else
    begin
      busyCnt_q <= progBusy ? busyCnt_q + 13'h0001 : 13'h0000;
      stopAge_q <= (scl && $rose(sdaIn)) ? 4'h0 : ((stopAge_q == 4'hF) ? 4'hF : stopAge_q + 4'h1);
    end
  end

  sequence stopEdge_s;
    scl && $rose(sdaIn);
  endsequence

  drive_low_only_a: assert property (sdaOe |-> !sdaOut) else $error("line driven high");
  oe_edge_a: assert property ($changed(sdaOe) |-> !scl) else $error("drive moved, clock high");
  busy_len_a: assert property ($fell(progBusy) |-> busyCnt_q == 13'(eep_pkg::PROG_CYCLES))
    else $error("programming time wrong");
  busy_nack_a: assert property ($rose(sdaOe) |-> !$past(progBusy, 2))
    else $error("answered while busy");
  lock_sticky_a: assert property (idLocked |=> idLocked) else $error("lock dropped");
  lock_commit_a: assert property ($rose(idLocked) |-> $past(progBusy) || $past(progBusy, 2))
    else $error("lock outside programming");
  wp_no_prog_a: assert property ($rose(progBusy) |-> !$past(writeProtect, 16))
    else $error("programming while protected");
  prog_after_stop_a: assert property ($rose(progBusy) |-> stopAge_q < 4'hA)
    else $error("programming without Stop");
  cover property (stopEdge_s ##[1:8] $rose(progBusy));
endmodule : eep_slave_properties

bind eep_i2c_slave eep_slave_properties eep_slave_properties_inst (.clk(clk), .rst(rst),
  .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipAddrStraps(chipAddrStraps),
  .writeProtect(writeProtect), .progBusy(progBusy), .idLocked(idLocked));

// ==== sim/eep_mst_model.sv ====
// Behavioural bus master that clocks the link and pulls the data line.
`timescale 1ns/1ps
module eep_mst_model (
  output logic scl, // Serial clock, parked high between frames.
  output logic sdaLow, // High while the master pulls the data line low.
  input wire logic sdaIn // Resolved data line.
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // A repeated Start first lifts the clock with the line released.
  task startC;
    if (!scl)
    begin
      #16 sdaLow = 1'b0;
      #16 scl = 1'b1;
      #16;
    end
    sdaLow = 1'b1;
    #32 scl = 1'b0;
  endtask : startC

  // The line is pulled low in the low phase and released while the clock is high; the slave needs the clock high a while to see Stop.
  task stopC;
    #16 sdaLow = 1'b1;
    #16 scl = 1'b1;
    #32 sdaLow = 1'b0;
    #200;
  endtask : stopC

  task bitX(input logic b, output logic r);
    #16 sdaLow = !b;
    #16 scl = 1'b1;
    #31 r = sdaIn;
    #1 scl = 1'b0;
  endtask : bitX

  task wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitX(d[i], r);
    bitX(1'b1, r);
    ack = !r;
  endtask : wrByte

  task rdByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitX(1'b1, r);
      d[i] = r;
    end
    bitX(last, r);
  endtask : rdByte
endmodule : eep_mst_model

// ==== sim/eep_i2c_slave_tb_top.sv ====
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/1ps
module eep_i2c_slave_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sdaLow;
  logic sdaIn;
  logic sdaOut;
  logic sdaOe;
  logic [2:0] straps = 3'h5;
  logic wp = 1'b0;
  logic progBusy;
  logic idLocked;
  logic ack;
  logic [7:0] rdData;
  int n_mismatch = 0;
  int num_checks = 0;

  always #4 clk = ~clk;
  // The line has a pull-up, so it reads high unless someone pulls it low.
  assign sdaIn = !((sdaOe && !sdaOut) || sdaLow);

  eep_i2c_slave eep_i2c_slave_inst (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chipAddrStraps(straps), .writeProtect(wp),
    .progBusy(progBusy), .idLocked(idLocked));
  eep_mst_model eep_mst_model_inst (.scl(scl), .sdaLow(sdaLow), .sdaIn(sdaIn));

  task final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task chkF(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask : chkF

  task chkB(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask : chkB

  task setIn(input logic [2:0] s, input logic w);
    @(posedge clk);
    straps <= s;
    wp <= w;
    #3;
  endtask : setIn

  task waitIdle;
    int k;
    k = 0;
    while (progBusy !== 1'b0 && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 4000)
    begin
      n_mismatch++;
      $display("[ERR] %0t programming never ended", $time);
      final_report();
    end
    @(posedge clk);
    #3;
  endtask : waitIdle

  task sel(input logic [3:0] typ, input logic [2:0] cs, input logic rw, input logic exp);
    eep_mst_model_inst.startC();
    eep_mst_model_inst.wrByte({typ, cs, rw}, ack);
    chkF(ack, exp);
  endtask : sel

  task adr(input logic [7:0] hi, input logic [7:0] lo);
    eep_mst_model_inst.wrByte(hi, ack);
    chkF(ack, 1'b1);
    eep_mst_model_inst.wrByte(lo, ack);
    chkF(ack, 1'b1);
  endtask : adr

  task wr(input logic [3:0] typ, input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] d, input int n, input logic exp);
    sel(typ, straps, 1'b0, 1'b1);
    adr(hi, lo);
    for (int i = 0; i < n; i++)
    begin
      eep_mst_model_inst.wrByte(d + 8'(i), ack);
      chkF(ack, exp);
    end
    eep_mst_model_inst.stopC();
  endtask : wr

  task rd(input logic [3:0] typ, input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] exp);
    sel(typ, straps, 1'b0, 1'b1);
    adr(hi, lo);
    sel(typ, straps, 1'b1, 1'b1);
    eep_mst_model_inst.rdByte(1'b1, rdData);
    eep_mst_model_inst.stopC();
    chkB(rdData, exp);
  endtask : rd

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #3;
    // Two bytes from the last offset of a page; the second wraps to the page start.
    wr(4'hA, 8'h00, 8'h3F, 8'h11, 2, 1'b1);
    chkF(progBusy, 1'b1);
    sel(4'hA, 3'h5, 1'b0, 1'b0);
    eep_mst_model_inst.stopC();
    waitIdle();
    rd(4'hA, 8'h00, 8'h3F, 8'h11);
    rd(4'hA, 8'h00, 8'h20, 8'h12);
    for (int i = 0; i < 8; i++)
    begin
      sel(4'hA, 3'(i), 1'b0, 3'(i) == 3'h5);
      eep_mst_model_inst.stopC();
      waitIdle();
    end
    for (int t = 0; t < 16; t++)
    begin
      sel(4'(t), 3'h5, 1'b0, (4'(t) == 4'hA) || (4'(t) == 4'hB));
      eep_mst_model_inst.stopC();
      waitIdle();
    end
    setIn(3'h0, 1'b0);
    sel(4'hA, 3'h0, 1'b0, 1'b1);
    eep_mst_model_inst.stopC();
    waitIdle();
    setIn(3'h5, 1'b1);
    wr(4'hA, 8'h00, 8'h3F, 8'h77, 2, 1'b0);
    chkF(progBusy, 1'b0);
    waitIdle();
    setIn(3'h5, 1'b0);
    rd(4'hA, 8'h00, 8'h3F, 8'h11);
    wr(4'hB, 8'h00, 8'h03, 8'h5A, 1, 1'b1);
    waitIdle();
    rd(4'hB, 8'h00, 8'h03, 8'h5A);
    wr(4'hB, 8'h04, 8'h00, 8'h00, 1, 1'b1);
    waitIdle();
    chkF(idLocked, 1'b1);
    wr(4'hB, 8'h00, 8'h03, 8'h33, 1, 1'b0);
    waitIdle();
    rd(4'hB, 8'h00, 8'h03, 8'h5A);
    final_report();
  end
endmodule : eep_i2c_slave_tb_top
